// [rug_consts.svh]
`ifndef RUG_CONSTS_SVH
`define RUG_CONSTS_SVH

// Register byte addresses on the AHB-Lite slave.
`define RUG_ADDR_KEY0        8'h00
`define RUG_ADDR_KEY1        8'h04
`define RUG_ADDR_KEY2        8'h08
`define RUG_ADDR_KEY3        8'h0c
`define RUG_ADDR_KEY4        8'h10
`define RUG_ADDR_KEY5        8'h14
`define RUG_ADDR_KEY6        8'h18
`define RUG_ADDR_KEY7        8'h1c
`define RUG_ADDR_FAIL_CNT    8'h20
`define RUG_ADDR_LOADER      8'h24
`define RUG_ADDR_LOADER_N    8'h28
`define RUG_ADDR_MODE        8'h2c
`define RUG_ADDR_ATTEMPT     8'h30
`define RUG_ADDR_STATUS      8'h34
`define RUG_ADDR_TRY0        8'h38
`define RUG_ADDR_TRY1        8'h3c

// Field values.
`define RUG_MODE_DISABLED    4'h5
`define RUG_FAIL_LIMIT       8'h08
`define RUG_KEY_ALL_ZERO     8'h00
`define RUG_KEY_ALL_ONE      8'hff
`define RUG_LOADER_ON        8'h55
`define RUG_LOADER_ON_N      8'haa

// Reset values.
`define RUG_RST_KEY          8'h00
`define RUG_RST_FAIL_CNT     8'h00
`define RUG_RST_MODE         4'h5
`define RUG_RST_LOADER       8'h00

// Status bit positions.
`define RUG_ST_UNLOCKED      0
`define RUG_ST_ERASE         1
`define RUG_ST_LOADER        2
`define RUG_ST_KEYS_BAD      3
`define RUG_ST_ENABLED       4

`endif

// [rug_guard.sv]
// Chosen here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ns
`include "rug_consts.svh"
// What this block does
// RULE1: Key bytes must be neither 00 nor FF.
// RULE2: Counter loads only while mode reads 0101.
// RULE3: Wrong keys while enabled increment counter.
// RULE4: Counter reaching 08 erases flash and EEPROM.
// RULE5: Loader option 55 with AA forces bootloader.
// RULE6: Matching keys unlock, counter stays unchanged.
module rug_guard (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rstn,
    // AHB-Lite slave.
    input wire rug_pkg::rug_ahb_req_t ahb_req,
    output rug_pkg::rug_ahb_rsp_t ahb_rsp,
    // Device controls.
    output logic unprotect_q,
    output logic erase_req_q,
    output logic loader_force_q
);
    import rug_pkg::*;

    logic [63:0] key_q, key_d;
    logic [63:0] try_q, try_d;
    logic [7:0] fail_q, fail_d;
    logic [7:0] ldr_q, ldr_d;
    logic [7:0] ldr_n_q, ldr_n_d;
    logic [3:0] mode_q, mode_d;
    logic unprotect_d, erase_req_d, loader_force_d;
    rug_state_t state_q, state_d;
    logic [7:0] waddr_q, waddr_d;
    logic wpend_q, wpend_d;
    logic [31:0] rdata_q, rdata_d;
    logic match, stored_valid, enabled, start, bad_keys;

    rug_key_compare u_cmp (
        .stored(key_q),
        .supplied(try_q),
        .match(match),
        .stored_valid(stored_valid)
    );

    // Any mode pattern other than the disabled one enables the feature.
    assign enabled = mode_q != `RUG_MODE_DISABLED;
    assign bad_keys = !stored_valid;

    // Any accepted transfer this cycle starts a data phase next cycle.
    logic take;
    assign take = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];

    // Read data is captured in the address phase so it stands through the data phase.
    function automatic logic [31:0] rd(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (a)
            `RUG_ADDR_KEY0: v = {24'h0, key_q[7:0]};
            `RUG_ADDR_KEY1: v = {24'h0, key_q[15:8]};
            `RUG_ADDR_KEY2: v = {24'h0, key_q[23:16]};
            `RUG_ADDR_KEY3: v = {24'h0, key_q[31:24]};
            `RUG_ADDR_KEY4: v = {24'h0, key_q[39:32]};
            `RUG_ADDR_KEY5: v = {24'h0, key_q[47:40]};
            `RUG_ADDR_KEY6: v = {24'h0, key_q[55:48]};
            `RUG_ADDR_KEY7: v = {24'h0, key_q[63:56]};
            `RUG_ADDR_FAIL_CNT: v = {24'h0, fail_q};
            `RUG_ADDR_LOADER: v = {24'h0, ldr_q};
            `RUG_ADDR_LOADER_N: v = {24'h0, ldr_n_q};
            `RUG_ADDR_MODE: v = {28'h0, mode_q};
            `RUG_ADDR_TRY0: v = try_q[31:0];
            `RUG_ADDR_TRY1: v = try_q[63:32];
            `RUG_ADDR_STATUS: begin
                v[`RUG_ST_UNLOCKED] = unprotect_q;
                v[`RUG_ST_ERASE] = erase_req_q;
                v[`RUG_ST_LOADER] = loader_force_q;
                v[`RUG_ST_KEYS_BAD] = bad_keys;
                v[`RUG_ST_ENABLED] = enabled;
            end
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction : rd

    always_comb begin
        key_d = key_q;
        try_d = try_q;
        fail_d = fail_q;
        ldr_d = ldr_q;
        ldr_n_d = ldr_n_q;
        mode_d = mode_q;
        waddr_d = waddr_q;
        wpend_d = 1'b0;
        rdata_d = rdata_q;
        start = 1'b0;
        if (take) begin
            waddr_d = ahb_req.haddr[7:0];
            wpend_d = ahb_req.hwrite;
            if (!ahb_req.hwrite) begin
                rdata_d = rd(ahb_req.haddr[7:0]);
            end
        end
        // Write data trails its address by one cycle, hence the held address.
        if (wpend_q) begin
            case (waddr_q)
                `RUG_ADDR_KEY0: key_d[7:0] = ahb_req.hwdata[7:0];
                `RUG_ADDR_KEY1: key_d[15:8] = ahb_req.hwdata[7:0];
                `RUG_ADDR_KEY2: key_d[23:16] = ahb_req.hwdata[7:0];
                `RUG_ADDR_KEY3: key_d[31:24] = ahb_req.hwdata[7:0];
                `RUG_ADDR_KEY4: key_d[39:32] = ahb_req.hwdata[7:0];
                `RUG_ADDR_KEY5: key_d[47:40] = ahb_req.hwdata[7:0];
                `RUG_ADDR_KEY6: key_d[55:48] = ahb_req.hwdata[7:0];
                `RUG_ADDR_KEY7: key_d[63:56] = ahb_req.hwdata[7:0];
                `RUG_ADDR_FAIL_CNT: begin
                    if (!enabled) begin
                        fail_d = ahb_req.hwdata[7:0]; // see RULE2
                    end
                end
                `RUG_ADDR_LOADER: ldr_d = ahb_req.hwdata[7:0];
                `RUG_ADDR_LOADER_N: ldr_n_d = ahb_req.hwdata[7:0];
                `RUG_ADDR_MODE: mode_d = ahb_req.hwdata[3:0];
                `RUG_ADDR_TRY0: try_d[31:0] = ahb_req.hwdata;
                `RUG_ADDR_TRY1: try_d[63:32] = ahb_req.hwdata;
                `RUG_ADDR_ATTEMPT: start = ahb_req.hwdata[0];
                default: ;
            endcase
        end
    end

    // The attempt is judged one cycle after the start write, on settled keys.
    always_comb begin
        state_d = state_q;
        unprotect_d = unprotect_q;
        erase_req_d = erase_req_q;
        // Both the option byte and its complement must agree to force the loader.
        loader_force_d = ldr_q == `RUG_LOADER_ON
            && ldr_n_q == `RUG_LOADER_ON_N; // see RULE5
        unique case (state_q)
            RUG_IDLE: begin
                if (start && enabled && !erase_req_q) begin
                    state_d = RUG_CHECK;
                end
            end
            RUG_CHECK: begin
                state_d = RUG_DONE;
                // Invalid stored keys never unlock; such an attempt counts as wrong.
                if (match && stored_valid) begin
                    unprotect_d = 1'b1; // see RULE6
                end else begin
                    unprotect_d = 1'b0;
                end
            end
            RUG_DONE: state_d = RUG_IDLE;
            // The unused code returns to idle.
            default: state_d = RUG_IDLE;
        endcase
        // Erase latches until reset and keeps protection in place.
        if (fail_q == `RUG_FAIL_LIMIT) begin
            erase_req_d = 1'b1; // see RULE4
            unprotect_d = 1'b0;
        end
    end

    // The increment overrides a bus load of the counter; the two never meet,
    // because a load needs the feature disabled and an increment needs it enabled.
    logic [7:0] fail_n;
    always_comb begin
        fail_n = fail_d;
        if (state_q == RUG_CHECK && !(match && stored_valid) && enabled) begin
            fail_n = fail_q + 8'h01; // see RULE3
        end
    end

    // Bus-side state: data-phase bookkeeping and read data.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            waddr_q <= 8'h00;
            wpend_q <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            waddr_q <= waddr_d;
            wpend_q <= wpend_d;
            rdata_q <= rdata_d;
        end
    end

    // Option bytes, supplied key and the failed-attempt counter.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            key_q <= {8{`RUG_RST_KEY}};
            try_q <= 64'h0;
            fail_q <= `RUG_RST_FAIL_CNT;
            ldr_q <= `RUG_RST_LOADER;
            ldr_n_q <= `RUG_RST_LOADER;
            mode_q <= `RUG_RST_MODE;
        end else begin
            key_q <= key_d;
            try_q <= try_d;
            fail_q <= fail_n;
            ldr_q <= ldr_d;
            ldr_n_q <= ldr_n_d;
            mode_q <= mode_d;
        end
    end

    // Attempt sequencer and the registered device controls.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_q <= RUG_IDLE;
            unprotect_q <= 1'b0;
            erase_req_q <= 1'b0;
            loader_force_q <= 1'b0;
        end else begin
            state_q <= state_d;
            unprotect_q <= unprotect_d;
            erase_req_q <= erase_req_d;
            loader_force_q <= loader_force_d;
        end
    end

    // Zero wait states and always OKAY: the slave never stalls the bus.
    assign ahb_rsp = {rdata_q, 1'b1, 1'b0};
endmodule : rug_guard

// [rug_guard_monitor.sv]
`timescale 1ns/1ns
`include "rug_consts.svh"
module rug_guard_monitor (
    input wire logic mclk,
    input wire logic rstn,
    input wire rug_pkg::rug_ahb_req_t ahb_req,
    input wire rug_pkg::rug_ahb_rsp_t ahb_rsp,
    input wire logic unprotect_q,
    input wire logic erase_req_q,
    input wire logic loader_force_q
);
    import rug_pkg::*;
    logic [3:0] since_q;
    logic [3:0] since_d;
    logic [1:0] lsince_q;
    logic [1:0] lsince_d;
    logic take;
    // Cycles since the last unlock attempt or counter load, and since the last
    // loader option write, both saturating.
    always_comb begin
        take = ahb_req.hsel & ahb_req.hready & ahb_req.htrans[1];
        since_d = (since_q == 4'hf) ? since_q : since_q + 4'h1;
        lsince_d = (lsince_q == 2'h3) ? lsince_q : lsince_q + 2'h1;
        if (take && ahb_req.hwrite && (ahb_req.haddr[7:0] == `RUG_ADDR_ATTEMPT
            || ahb_req.haddr[7:0] == `RUG_ADDR_FAIL_CNT)) begin
            since_d = 4'h0;
        end
        if (take && ahb_req.hwrite && (ahb_req.haddr[7:0] == `RUG_ADDR_LOADER
            || ahb_req.haddr[7:0] == `RUG_ADDR_LOADER_N)) begin
            lsince_d = 2'h0;
        end
    end
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            since_q <= 4'hf;
            lsince_q <= 2'h3;
        end else begin
            since_q <= since_d;
            lsince_q <= lsince_d;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    ready_okay_a: assert property (ahb_rsp.hreadyout && !ahb_rsp.hresp)
        else $error("slave stalled or answered with an error");
    rdata_hold_a: assert property (!(take && !ahb_req.hwrite) |=> $stable(ahb_rsp.hrdata))
        else $error("read data changed without a read");
    unlock_cause_a: assert property ($changed(unprotect_q) |-> since_q <= 4'h4)
        else $error("unlock changed without an attempt");
    erase_cause_a: assert property ($rose(erase_req_q) |-> since_q <= 4'h5)
        else $error("erase raised without an attempt");
    erase_sticky_a: assert property (erase_req_q |=> erase_req_q)
        else $error("erase request dropped");
    erase_locks_a: assert property (erase_req_q |-> !unprotect_q)
        else $error("unlocked while erasing");
    loader_cause_a: assert property ($changed(loader_force_q) |-> lsince_q <= 2'h2)
        else $error("loader force changed without an option write");
endmodule : rug_guard_monitor
bind rug_guard rug_guard_monitor mon_u (.mclk, .rstn, .ahb_req, .ahb_rsp, .unprotect_q,
    .erase_req_q, .loader_force_q);

// [rug_host.sv]
`timescale 1ns/1ns
module rug_host (
    input wire logic mclk,
    input wire rug_pkg::rug_ahb_rsp_t ahb_rsp,
    output rug_pkg::rug_ahb_req_t ahb_req
);
    import rug_pkg::*;
    rug_ahb_req_t q = '0;
    always_comb begin
        ahb_req = q;
        ahb_req.hready = ahb_rsp.hreadyout;
    end
    // Released write data shows its inverse so stale values cannot match.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rdv);
        q.hsel <= 1'b1;
        q.htrans <= 2'b10;
        q.haddr <= {24'h0, a};
        q.hwrite <= w;
        q.hsize <= 3'h2;
        do @(posedge mclk); while (!ahb_rsp.hreadyout);
        q.htrans <= 2'b00;
        q.hsel <= 1'b0;
        q.hwdata <= wd;
        do @(posedge mclk); while (!ahb_rsp.hreadyout);
        rdv = ahb_rsp.hrdata;
        q.hwdata <= ~wd;
    endtask : xfer
endmodule : rug_host

// [rug_key_compare.sv]
`timescale 1ns/1ns
`include "rug_consts.svh"
module rug_key_compare (
    // Stored and supplied key bytes.
    input wire logic [63:0] stored,
    input wire logic [63:0] supplied,
    // Comparison results.
    output logic match,
    output logic stored_valid
);
    logic [7:0] eq;
    logic [7:0] ok;
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_byte
            assign eq[i] = stored[8*i +: 8] == supplied[8*i +: 8];
            assign ok[i] = stored[8*i +: 8] != `RUG_KEY_ALL_ZERO
                && stored[8*i +: 8] != `RUG_KEY_ALL_ONE; // see RULE1
        end
    endgenerate
    assign match = &eq; // see RULE6
    assign stored_valid = &ok;
endmodule : rug_key_compare

// [rug_pkg.sv]
package rug_pkg;
    typedef struct packed {
        logic [1:0] htrans;
        logic [31:0] haddr;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hsel;
        logic hready;
    } rug_ahb_req_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } rug_ahb_rsp_t;

    typedef enum logic [1:0] {
        RUG_IDLE = 2'b00,
        RUG_CHECK = 2'b01,
        RUG_DONE = 2'b11
    } rug_state_t;
endpackage : rug_pkg

// [testbench.sv]
`timescale 1ns/1ns
`include "rug_consts.svh"
module testbench;
    import rug_pkg::*;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    rug_ahb_req_t ahb_req;
    rug_ahb_rsp_t ahb_rsp;
    logic unprotect_q;
    logic erase_req_q;
    logic loader_force_q;
    logic [31:0] v;
    logic [63:0] good = 64'h8877665544332211;
    int num_errors = 0;
    int tests_run = 0;
    initial begin
        forever #2 mclk = ~mclk;
    end
    rug_guard dut_u (.mclk, .rstn, .ahb_req, .ahb_rsp, .unprotect_q, .erase_req_q,
        .loader_force_q);
    rug_host host_u (.mclk, .ahb_rsp, .ahb_req);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host_u.xfer(1'b1, a, d, v);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        host_u.xfer(1'b0, a, 32'h0, v);
        chk(v, e);
    endtask : rd
    task automatic att(input logic [63:0] t);
        wr(`RUG_ADDR_TRY0, t[31:0]);
        wr(`RUG_ADDR_TRY1, t[63:32]);
        wr(`RUG_ADDR_ATTEMPT, 32'h1);
        repeat (4) @(posedge mclk);
    endtask : att
    task automatic outs(input logic [2:0] e);
        #1 chk({29'h0, loader_force_q, erase_req_q, unprotect_q}, {29'h0, e});
        @(posedge mclk);
    endtask : outs
    task automatic results();
        if (num_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results
    initial begin
        repeat (2000) @(posedge mclk);
        num_errors++;
        results();
    end
    initial begin
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        rd(`RUG_ADDR_MODE, 32'h5);
        rd(`RUG_ADDR_FAIL_CNT, 32'h0);
        rd(8'h40, 32'h0);
        wr(`RUG_ADDR_FAIL_CNT, 32'h5);
        for (int i = 0; i < 8; i++) begin
            wr(8'(4 * i), {24'h0, good[8*i +: 8]});
        end
        wr(`RUG_ADDR_MODE, 32'ha);
        wr(`RUG_ADDR_FAIL_CNT, 32'h0);
        rd(`RUG_ADDR_FAIL_CNT, 32'h5);
        att(good);
        outs(3'b001);
        rd(`RUG_ADDR_FAIL_CNT, 32'h5);
        rd(`RUG_ADDR_STATUS, 32'h11);
        rd(`RUG_ADDR_TRY1, 32'h88776655);
        rd(`RUG_ADDR_KEY7, 32'h88);
        wr(`RUG_ADDR_KEY0, 32'h0);
        att({good[63:8], 8'h00});
        outs(3'b000);
        rd(`RUG_ADDR_STATUS, 32'h18);
        wr(`RUG_ADDR_KEY0, 32'h11);
        att(~good);
        rd(`RUG_ADDR_FAIL_CNT, 32'h7);
        att(good ^ 64'h1);
        outs(3'b010);
        rd(`RUG_ADDR_FAIL_CNT, 32'h8);
        rd(`RUG_ADDR_STATUS, 32'h12);
        att(good);
        outs(3'b010);
        for (int i = 0; i < 4; i++) begin
            wr(`RUG_ADDR_LOADER, i[0] ? 32'h55 : 32'h54);
            wr(`RUG_ADDR_LOADER_N, i[1] ? 32'haa : 32'hab);
            repeat (2) @(posedge mclk);
            outs({i == 3, 2'b10});
        end
        rd(`RUG_ADDR_LOADER, 32'h55);
        rd(`RUG_ADDR_STATUS, 32'h16);
        results();
    end
endmodule : testbench
